// File: rtl/ecr_control_regs.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ecr_map.svh"

module ecr_control_regs #(
  parameter int HOLD_200_CYC = `ECR_HOLD_200_MS * `ECR_CLK_KHZ,
  parameter int HOLD_100_CYC = `ECR_HOLD_100_MS * `ECR_CLK_KHZ,
  parameter int HOLD_150_CYC = `ECR_HOLD_150_MS * `ECR_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Level and noise estimates, dB
  input  wire logic [7:0]  tx_power,
  input  wire logic [7:0]  tx_floor,
  input  wire logic [7:0]  rx_power,
  input  wire logic [7:0]  rx_floor,
  // Canceller and howl events
  input  wire logic        howl_evt,
  input  wire logic        converged,
  input  wire logic        line_path_absent,
  input  wire logic        line_path_found,
  input  wire logic [1:0]  line_far_noise_setting,
  // Detector results
  output logic             tx_speech,
  output logic             rx_speech,
  output logic             far_speech,
  // Canceller configuration
  output logic [8:0]       acoustic_taps,
  output logic [8:0]       line_taps,
  output logic             line_adapt,
  output logic             line_zero,
  output logic             line_freeze,
  output logic             line_canceller_en,
  output logic             line_retrain,
  // Gain and suppression
  output logic             tx_agc_en,
  output logic [4:0]       tx_agc_level,
  output logic [2:0]       tx_atten_steps,
  output logic             tx_mute,
  output logic             rx_suppress,
  output logic [3:0]       noise_rise,
  output logic [9:0]       dt_attack_ms,
  output logic [9:0]       tx_decay_ms,
  output logic [9:0]       rx_decay_ms,
  // Half-duplex engine
  output logic             hd_active,
  output logic             tx_owner,
  output logic             rx_owner
);

  ecr_pkg::ecr_state_t s;
  ecr_pkg::ecr_state_t next_s;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // Reserved code 11 falls back to the reset threshold
  function automatic logic [8:0] thr_db(input logic [1:0] code);
    logic [8:0] v;
    v = 9'h006;
    case (code)
      2'b01: v = 9'h009;
      2'b10: v = 9'h00c;
      default: v = 9'h006;
    endcase
    return v;
  endfunction : thr_db

  // Speech when power exceeds floor plus threshold, no wrap
  function automatic logic speech(input logic [7:0] pwr,
                                  input logic [7:0] flr,
                                  input logic [1:0] code);
    return {1'b0, pwr} > ({1'b0, flr} + thr_db(code));
  endfunction : speech

  // Holdover in cycles; reserved code acts as the longest delay
  function automatic logic [22:0] hold_cyc(input logic [1:0] code);
    logic [22:0] v;
    v = 23'(HOLD_200_CYC - 1);
    case (code)
      2'b01: v = 23'(HOLD_100_CYC - 1);
      2'b10: v = 23'(HOLD_150_CYC - 1);
      default: v = 23'(HOLD_200_CYC - 1);
    endcase
    return v;
  endfunction : hold_cyc

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------

  logic [1:0] f_txthr;
  logic [1:0] f_taps;
  logic [3:0] f_tgain;
  logic       f_rsoff;
  logic [1:0] f_lcc;
  logic       f_reeng_off;
  logic [1:0] f_rxthr;
  logic [1:0] f_rsthr;
  logic [1:0] f_rise;
  logic [1:0] f_holdover_delay;
  logic       f_howl;
  logic       f_tdt;
  logic       f_rdt;
  logic       f_idle;

  // Fields straight out of the two stored words
  assign f_txthr     = s.reg1[`ECR_TXTHR_LSB +: 2];
  assign f_taps      = s.reg1[`ECR_TAPS_LSB +: 2];
  assign f_tgain     = s.reg1[`ECR_TGAIN_LSB +: 4];
  assign f_rsoff     = s.reg1[`ECR_RSOFF_BIT];
  assign f_lcc       = s.reg1[`ECR_LCC_LSB +: 2];
  assign f_reeng_off = s.reg1[`ECR_REENG_BIT];
  assign f_rxthr     = s.reg2[`ECR_RXTHR_LSB +: 2];
  assign f_rsthr     = s.reg2[`ECR_RSTHR_LSB +: 2];
  assign f_rise      = s.reg2[`ECR_RISE_LSB +: 2];
  assign f_holdover_delay      = s.reg2[`ECR_HOLDOVER_DELAY_LSB +: 2];
  assign f_howl      = s.reg2[`ECR_HOWL_BIT];
  assign f_tdt       = s.reg2[`ECR_TDT_BIT];
  assign f_rdt       = s.reg2[`ECR_RDT_BIT];
  assign f_idle      = s.reg2[`ECR_IDLE_BIT];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  logic       setup;
  logic       access;
  logic [3:0] sel_code;
  logic       retrain;

  always_comb begin
    next_s   = s;
    setup    = psel && !penable;
    access   = psel && penable && s.pready;
    sel_code = pwdata[3:0];
    retrain  = 1'b0;

    // APB: answer is prepared in setup so pready comes from a flop
    next_s.pready  = setup;
    next_s.prdata  = 32'h0000_0000;
    next_s.pslverr = 1'b0;
    if (setup) begin
      case (paddr)
        `ECR_ADDR_CTRL: begin
          next_s.pslverr = pwrite && (sel_code != `ECR_SEL_REG1)
                                  && (sel_code != `ECR_SEL_REG2);
        end
        `ECR_ADDR_REG1: begin
          next_s.prdata  = {16'h0000, s.reg1};
          next_s.pslverr = pwrite;
        end
        `ECR_ADDR_REG2: begin
          next_s.prdata  = {16'h0000, s.reg2};
          next_s.pslverr = pwrite;
        end
        `ECR_ADDR_STAT: begin
          next_s.prdata  = {24'h00_0000, s.lc == ecr_pkg::ECR_LC_ON, s.hd_active,
                            s.hd, s.far_speech, s.rx_speech, s.tx_speech};
          next_s.pslverr = pwrite;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // route upper twelve bits by select code
    if (access && pwrite && !s.pslverr && paddr == `ECR_ADDR_CTRL) begin
      if (sel_code == `ECR_SEL_REG1) begin
        next_s.reg1 = {pwdata[15:4], `ECR_SEL_REG1};
      end
      if (sel_code == `ECR_SEL_REG2) begin
        next_s.reg2 = {pwdata[15:4], `ECR_SEL_REG2};
      end
    end

    next_s.tx_speech  = speech(tx_power, tx_floor, f_txthr);
    next_s.rx_speech  = speech(rx_power, rx_floor, f_rxthr);
    next_s.far_speech = speech(rx_power, rx_floor, f_rsthr);

    // suppress unless far end is active
    next_s.rx_suppress = !f_rsoff && !s.far_speech;

    case (f_taps)
      2'b00: begin
        next_s.acoustic_taps = 9'd444;
        next_s.line_taps     = 9'd64;
      end
      2'b01: begin
        next_s.acoustic_taps = 9'd380;
        next_s.line_taps     = 9'd128;
      end
      2'b10: begin
        next_s.acoustic_taps = 9'd316;
        next_s.line_taps     = 9'd192;
      end
      default: begin
        next_s.acoustic_taps = 9'd252;
        next_s.line_taps     = 9'd256;
      end
    endcase

    // AGC above 0 dB, 3 dB attenuation steps below
    next_s.tx_mute        = f_tgain == `ECR_GAIN_MUTE;
    next_s.tx_agc_en      = f_tgain < `ECR_GAIN_ZERO;
    next_s.tx_agc_level   = 5'h00;
    next_s.tx_atten_steps = 3'h0;
    if (f_tgain < `ECR_GAIN_ZERO) begin
      next_s.tx_agc_level = 5'(`ECR_GAIN_TOP - 5'(3 * f_tgain));
    end else if (f_tgain != `ECR_GAIN_MUTE) begin
      next_s.tx_atten_steps = 3'(f_tgain - `ECR_GAIN_ZERO);
    end

    // coefficient mode; reserved code adapts normally
    next_s.line_adapt  = f_lcc == 2'b00 || f_lcc == 2'b11;
    next_s.line_zero   = f_lcc == 2'b01;
    next_s.line_freeze = f_lcc == 2'b10;

    // noise rise rate, dB per second
    case (f_rise)
      2'b01: next_s.noise_rise = 4'h6;
      2'b10: next_s.noise_rise = 4'hc;
      default: next_s.noise_rise = 4'h3;
    endcase

    next_s.tx_decay_ms = f_tdt ? `ECR_DT_NORM_MS : `ECR_DT_SLOW_MS;
    next_s.rx_decay_ms = f_rdt ? `ECR_DT_NORM_MS : `ECR_DT_SLOW_MS;

    // Line canceller engagement
    case (s.lc)
      ecr_pkg::ECR_LC_ON: begin
        // drop only with non-zero far noise
        if (line_path_absent && line_far_noise_setting != 2'b00) begin
          next_s.lc = ecr_pkg::ECR_LC_OFF;
        end
      end
      ecr_pkg::ECR_LC_OFF: begin
        if (line_path_found && !f_reeng_off) begin
          next_s.lc = ecr_pkg::ECR_LC_ON;
          retrain   = 1'b1;
        end
      end
      default: next_s.lc = ecr_pkg::ECR_LC_ON;
    endcase
    next_s.line_retrain = retrain;

    // howl hold keeps half-duplex; set wins over clear
    if (converged && !(s.hd_by_howl && f_howl)) begin
      next_s.hd_active  = 1'b0;
      next_s.hd_by_howl = 1'b0;
    end
    if (retrain) begin
      next_s.hd_active = 1'b1;
    end
    if (howl_evt) begin
      next_s.hd_active  = 1'b1;
      next_s.hd_by_howl = 1'b1;
    end

    // Ownership engine, only while half-duplex
    case (s.hd)
      ecr_pkg::ECR_HD_IDLE: begin
        if (f_idle || s.tx_speech) begin
          next_s.hd = ecr_pkg::ECR_HD_TX;
        end else if (s.rx_speech) begin
          next_s.hd = ecr_pkg::ECR_HD_RX;
        end
      end
      ecr_pkg::ECR_HD_TX: begin
        if (!s.tx_speech) begin
          next_s.hd       = ecr_pkg::ECR_HD_HANG_TX;
          next_s.hold_cnt = hold_cyc(f_holdover_delay);
        end
      end
      ecr_pkg::ECR_HD_RX: begin
        if (!s.rx_speech) begin
          next_s.hd       = ecr_pkg::ECR_HD_HANG_RX;
          next_s.hold_cnt = hold_cyc(f_holdover_delay);
        end
      end
      ecr_pkg::ECR_HD_HANG_TX, ecr_pkg::ECR_HD_HANG_RX: begin
        // the other side cannot take over during holdover
        next_s.hold_cnt = s.hold_cnt - 23'h000001;
        if (s.hd == ecr_pkg::ECR_HD_HANG_TX && s.tx_speech) begin
          next_s.hd = ecr_pkg::ECR_HD_TX;
        end else if (s.hd == ecr_pkg::ECR_HD_HANG_RX && s.rx_speech) begin
          next_s.hd = ecr_pkg::ECR_HD_RX;
        end else if (s.hold_cnt == 23'h000000) begin
          next_s.hd = ecr_pkg::ECR_HD_IDLE;
        end
      end
      default: next_s.hd = ecr_pkg::ECR_HD_IDLE;
    endcase
    // Full duplex leaves nobody owning the channel
    if (!s.hd_active) begin
      next_s.hd       = ecr_pkg::ECR_HD_IDLE;
      next_s.hold_cnt = 23'h000000;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // Reset values match the documented field defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                <= '0;
      s.reg1           <= `ECR_RST_REG1;
      s.reg2           <= `ECR_RST_REG2;
      s.hd             <= ecr_pkg::ECR_HD_IDLE;
      s.lc             <= ecr_pkg::ECR_LC_ON;
      s.hd_active      <= 1'b1;
      s.acoustic_taps  <= 9'd316;
      s.line_taps      <= 9'd192;
      s.tx_decay_ms    <= `ECR_DT_SLOW_MS;
      s.rx_decay_ms    <= `ECR_DT_SLOW_MS;
      s.noise_rise     <= 4'h3;
      s.line_adapt     <= 1'b1;
      s.rx_suppress    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from the state flops except the constant dt_attack_ms
  // ---------------------------------------------------------------

  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign tx_speech         = s.tx_speech;
  assign rx_speech         = s.rx_speech;
  assign far_speech        = s.far_speech;
  assign acoustic_taps     = s.acoustic_taps;
  assign line_taps         = s.line_taps;
  assign line_adapt        = s.line_adapt;
  assign line_zero         = s.line_zero;
  assign line_freeze       = s.line_freeze;
  assign line_canceller_en = s.lc == ecr_pkg::ECR_LC_ON;
  assign line_retrain      = s.line_retrain;
  assign tx_agc_en         = s.tx_agc_en;
  assign tx_agc_level      = s.tx_agc_level;
  assign tx_atten_steps    = s.tx_atten_steps;
  assign tx_mute           = s.tx_mute;
  assign rx_suppress       = s.rx_suppress;
  assign noise_rise        = s.noise_rise;
  assign dt_attack_ms      = `ECR_DT_ATK_MS;
  assign tx_decay_ms       = s.tx_decay_ms;
  assign rx_decay_ms       = s.rx_decay_ms;
  assign hd_active         = s.hd_active;
  assign tx_owner          = s.hd == ecr_pkg::ECR_HD_TX || s.hd == ecr_pkg::ECR_HD_HANG_TX;
  assign rx_owner          = s.hd == ecr_pkg::ECR_HD_RX || s.hd == ecr_pkg::ECR_HD_HANG_RX;

endmodule : ecr_control_regs

// File: rtl/ecr_map.svh
// Function
// - Transmit speech when tx power beats tx noise floor by 6/9/12 dB.
// - Split one fixed tap pool between acoustic and line cancellers.
// - Tap split codes 444/64, 380/128, 316/192 (reset), 252/256.
// - Tx gain: AGC above 0 dB, attenuation steps below, top code mutes; reset is 0 dB.
// - Rx suppression attenuates rx unless far-end speech is present.
// - Rx suppression off bit: 0 enables (reset), 1 disables.
// - Line coefficients: 00 adapt, 01 held at zero, 10 frozen.
// - Reengage off bit 0: re-enable line canceller on path, half-duplex, retrain.
// - Line canceller disabled for missing path only with non-zero far noise.
// - Rx half-duplex detection threshold 6/9/12 dB above rx floor.
// - Rx suppression threshold 6/9/12 dB for far-end speech detection.
// - Noise estimator rise rate 3, 6 or 12 dB/s.
// - Holdover delay 200 ms (reset), 100 ms or 150 ms.
// - Howl hold bit: 0 disables (reset), 1 enables holding on howl.
// - Tx double-talk decay bit: 0 slow (reset), 1 normal.
// - Rx double-talk decay bit: 0 slow (reset), 1 normal.
// - Idle-to-transmit bit: 0 disabled (reset), 1 enabled.
// - With howl hold set, stay half-duplex after howl until bit clears.
// - Double-talk attack about 40 ms; decay 1 s slow or 100 ms normal.
// - With idle-to-transmit, half-duplex engine goes from idle to transmit.
// - After the owner goes idle, ownership changes wait the holdover delay.
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH
`define ECR_ADDR_CTRL   8'h00
`define ECR_ADDR_REG1   8'h04
`define ECR_ADDR_REG2   8'h08
`define ECR_ADDR_STAT   8'h0c
`define ECR_SEL_REG1    4'h2
`define ECR_SEL_REG2    4'h4
`define ECR_RST_REG1    16'h2a02
`define ECR_RST_REG2    16'h0004
`define ECR_TXTHR_LSB   14
`define ECR_TAPS_LSB    12
`define ECR_TGAIN_LSB   8
`define ECR_RSOFF_BIT   7
`define ECR_LCC_LSB     5
`define ECR_REENG_BIT   4
`define ECR_RXTHR_LSB   14
`define ECR_RSTHR_LSB   12
`define ECR_RISE_LSB    10
`define ECR_HOLDOVER_DELAY_LSB    8
`define ECR_HOWL_BIT    7
`define ECR_TDT_BIT     6
`define ECR_RDT_BIT     5
`define ECR_IDLE_BIT    4
`define ECR_GAIN_ZERO   4'ha
`define ECR_GAIN_MUTE   4'hf
`define ECR_GAIN_TOP    5'h1e
`define ECR_CLK_KHZ     25000
`define ECR_HOLD_200_MS 200
`define ECR_HOLD_100_MS 100
`define ECR_HOLD_150_MS 150
`define ECR_DT_ATK_MS   10'h028
`define ECR_DT_SLOW_MS  10'h3e8
`define ECR_DT_NORM_MS  10'h064
`endif

// File: rtl/ecr_pkg.sv
package ecr_pkg;
  // Half-duplex ownership engine
  typedef enum logic [2:0] {
    ECR_HD_IDLE    = 3'b000,
    ECR_HD_TX      = 3'b001,
    ECR_HD_RX      = 3'b010,
    ECR_HD_HANG_TX = 3'b011,
    ECR_HD_HANG_RX = 3'b100
  } ecr_hd_t;

  // Line canceller engagement
  typedef enum logic {
    ECR_LC_ON  = 1'b0,
    ECR_LC_OFF = 1'b1
  } ecr_lc_t;

  // All state of the block
  typedef struct packed {
    logic [15:0] reg1;
    logic [15:0] reg2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ecr_hd_t     hd;
    logic        hd_active;
    logic        hd_by_howl;
    ecr_lc_t     lc;
    logic [22:0] hold_cnt;
    logic        tx_speech;
    logic        rx_speech;
    logic        far_speech;
    logic [8:0]  acoustic_taps;
    logic [8:0]  line_taps;
    logic        tx_agc_en;
    logic [4:0]  tx_agc_level;
    logic [2:0]  tx_atten_steps;
    logic        tx_mute;
    logic        rx_suppress;
    logic        line_adapt;
    logic        line_zero;
    logic        line_freeze;
    logic        line_retrain;
    logic [3:0]  noise_rise;
    logic [9:0]  tx_decay_ms;
    logic [9:0]  rx_decay_ms;
  } ecr_state_t;
endpackage : ecr_pkg

// File: test/ecr_mcu_model.sv
`timescale 1ns/100ps
// ----------------
// Controller model
// ----------------
module ecr_mcu_model (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic hung;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // Bounded wait, so a dead slave cannot hang the run
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The access phase ends at the rising edge that sees pready high
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    if (n == 50) hung = 1'b1;
    // Released address and data show the inverse, never the stale value; pwrite keeps its value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic put_word(input logic [3:0] sel, input logic [11:0] v, output logic e);
    logic [31:0] q;
    xfer(8'h00, 1'b1, {16'h0000, v, sel}, q, e);
  endtask : put_word
endmodule : ecr_mcu_model

// File: test/ecr_control_regs_asserts.sv
`timescale 1ns/100ps
// -------
// Checker
// -------
module ecr_regs_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line canceller
  input wire logic        line_path_absent,
  input wire logic [1:0]  line_far_noise_setting,
  input wire logic        line_canceller_en,
  input wire logic        line_retrain,
  input wire logic        line_adapt,
  input wire logic        line_zero,
  input wire logic        line_freeze,
  input wire logic [8:0]  acoustic_taps,
  input wire logic [8:0]  line_taps,
  // Decay and ownership
  input wire logic [9:0]  dt_attack_ms,
  input wire logic [9:0]  tx_decay_ms,
  input wire logic        hd_active,
  input wire logic        tx_owner,
  input wire logic        rx_owner
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_wr;
  logic taps0_wr;
  // Accepted write, and one carrying tap code zero
  assign acc_wr = psel && penable && pready && pwrite;
  assign taps0_wr = acc_wr && paddr == 8'h00 && pwdata[3:0] == 4'h2 && pwdata[13:12] == 2'b00;
  property p_pool;
    acoustic_taps + line_taps == 10'd508;
  endproperty
  a_pool: assert property (p_pool) else $error("tap pool not fixed");
  property p_taps0;
    taps0_wr |-> ##2 acoustic_taps == 9'd444 && line_taps == 9'd64;
  endproperty
  a_taps0: assert property (p_taps0) else $error("tap code zero wrong");
  property p_coef;
    $onehot({line_adapt, line_zero, line_freeze});
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient mode not one-hot");
  property p_drop;
    $fell(line_canceller_en) |-> $past(line_path_absent) && $past(line_far_noise_setting) != 2'b00;
  endproperty
  a_drop: assert property (p_drop) else $error("line canceller dropped without cause");
  property p_reeng;
    $rose(line_canceller_en) |-> line_retrain && hd_active;
  endproperty
  a_reeng: assert property (p_reeng) else $error("re-engage without retrain");
  property p_pulse;
    line_retrain |=> !line_retrain;
  endproperty
  a_pulse: assert property (p_pulse) else $error("retrain longer than one cycle");
  property p_refuse;
    acc_wr && paddr != 8'h00 |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read-only write accepted");
  property p_decay;
    dt_attack_ms == 10'd40 && (tx_decay_ms == 10'd1000 || tx_decay_ms == 10'd100);
  endproperty
  a_decay: assert property (p_decay) else $error("double-talk timing wrong");
  property p_own;
    $fell(hd_active) |-> ##[0:3] (!tx_owner && !rx_owner);
  endproperty
  a_own: assert property (p_own) else $error("owner kept outside half-duplex");
  // Main scenarios reached
  c_retrain: cover property (line_retrain);
  c_drop: cover property ($fell(line_canceller_en));
  c_err: cover property (pslverr);
endmodule : ecr_regs_chk

bind ecr_control_regs ecr_regs_chk u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .line_path_absent(line_path_absent), .line_far_noise_setting(line_far_noise_setting),
  .line_canceller_en(line_canceller_en), .line_retrain(line_retrain),
  .line_adapt(line_adapt), .line_zero(line_zero), .line_freeze(line_freeze),
  .acoustic_taps(acoustic_taps), .line_taps(line_taps), .dt_attack_ms(dt_attack_ms),
  .tx_decay_ms(tx_decay_ms), .hd_active(hd_active), .tx_owner(tx_owner), .rx_owner(rx_owner));

// File: test/test_echo_control_config_regs.sv
`timescale 1ns/100ps
// -----
// Bench
// -----
module test_echo_control_config_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, howl_evt, converged;
  logic line_path_absent, line_path_found, tx_speech, rx_speech, far_speech, line_adapt;
  logic line_zero, line_freeze, line_canceller_en, line_retrain, tx_mute, rx_suppress;
  logic hd_active, tx_owner, rx_owner, tx_agc_en;
  logic [7:0] paddr, tx_power, tx_floor, rx_power, rx_floor;
  logic [31:0] pwdata, prdata;
  logic [1:0] line_far_noise_setting;
  logic [8:0] acoustic_taps, line_taps;
  logic [4:0] tx_agc_level;
  logic [2:0] tx_atten_steps;
  logic [3:0] noise_rise;
  logic [9:0] tx_decay_ms, rx_decay_ms;
  int fail_count, num_checks;
  int hold [3] = '{20, 10, 15};
  // Short holdover counts keep the run brief
  ecr_control_regs #(.HOLD_200_CYC(20), .HOLD_100_CYC(10), .HOLD_150_CYC(15)) u_dut (
    .dt_attack_ms(), .*);
  ecr_mcu_model u_mcu (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Sample 1 ns after the edge, once updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] s, input logic [11:0] v);
    logic e;
    u_mcu.put_word(s, v, e);
    chk(e, 0, "wr_err");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    u_mcu.xfer(a, 1'b0, 32'h0, q, e);
    chk(q, exp, what);
    chk(e, 0, "rd_err");
  endtask : rd
  task automatic t_reset();
    rd(8'h04, 32'h00002a02, "reg1");
    rd(8'h08, 32'h00000004, "reg2");
    rd(8'h0c, 32'h000000c0, "stat");
    chk({acoustic_taps, line_taps}, {9'd316, 9'd192}, "taps");
    chk({tx_agc_level, tx_atten_steps}, 8'h00, "gain");
    chk({rx_suppress, line_adapt}, 2'b11, "sup");
    chk(noise_rise, 3, "rise");
    chk({tx_decay_ms, rx_decay_ms}, {10'd1000, 10'd1000}, "decay");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_refuse();
    logic [31:0] q;
    logic e;
    u_mcu.put_word(4'h3, 12'hfff, e);
    chk(e, 1, "bad_sel");
    u_mcu.xfer(8'h04, 1'b1, 32'h0000fff2, q, e);
    chk(e, 1, "ro_wr");
    u_mcu.xfer(8'h10, 1'b0, 32'h0, q, e);
    chk(e, 1, "unmapped");
    rd(8'h04, 32'h00002a02, "kept");
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_tx();
    int c;
    for (c = 0; c < 4; c++) begin
      wr(4'h2, {2'b00, c[1:0], 8'ha0});
      tick(2);
      chk({acoustic_taps, line_taps}, {9'(444 - 64 * c), 9'(64 + 64 * c)}, "taps");
    end
    for (c = 0; c < 16; c++) begin
      wr(4'h2, {4'h2, c[3:0], 4'h0});
      tick(2);
      chk(tx_agc_en, c < 10, "agc_en");
      if (c == 15) chk(tx_mute, 1, "mute");
      else if (c > 10) chk(tx_atten_steps, c - 10, "atten");
      else chk(tx_agc_level, 30 - 3 * c, "agc");
    end
    for (c = 0; c < 4; c++) begin
      wr(4'h2, {8'h2a, c[0], c[1:0], 1'b0});
      tick(2);
      chk({line_adapt, line_zero, line_freeze}, c == 1 ? 3'b010 : c == 2 ? 3'b001 : 3'b100,
          "coef");
      chk(rx_suppress, !c[0], "sup");
      rd(8'h04, {16'h0, 8'h2a, c[0], c[1:0], 5'h02}, "reg1");
    end
    $display("t_tx done");
  endtask : t_tx
  task automatic t_rx();
    int c;
    for (c = 0; c < 3; c++) begin
      wr(4'h4, {4'h0, c[1:0], 6'h06});
      tick(2);
      chk(noise_rise, 3 << c, "rise");
      chk({tx_decay_ms, rx_decay_ms}, {10'd100, 10'd100}, "decay");
      rd(8'h08, {20'h0, c[1:0], 10'h064}, "reg2");
    end
    $display("t_rx done");
  endtask : t_rx
  task automatic t_speech();
    int c, k;
    for (c = 0; c < 3; c++) begin
      wr(4'h2, {c[1:0], 10'h2a0});
      wr(4'h4, {c[1:0], c[1:0], 8'h00});
      for (k = 0; k < 2; k++) begin
        @(posedge pclk);
        tx_floor <= 8'd20;
        rx_floor <= 8'd20;
        tx_power <= 8'(26 + 3 * c + k);
        rx_power <= 8'(26 + 3 * c + k);
        tick(2);
        chk({tx_speech, rx_speech, far_speech}, {3{k[0]}}, "speech");
      end
    end
    @(posedge pclk);
    tx_power <= 8'd0;
    rx_power <= 8'd0;
    tick(30);
    $display("t_speech done");
  endtask : t_speech
  task automatic t_hold();
    int c;
    for (c = 0; c < 3; c++) begin
      wr(4'h4, {6'h00, c[1:0], 4'h0});
      @(posedge pclk);
      tx_power <= 8'd60;
      tick(4);
      chk(tx_owner, 1, "own");
      @(posedge pclk);
      tx_power <= 8'd0;
      tick(hold[c] + 1);
      chk(tx_owner, 1, "hang");
      tick(1);
      chk(tx_owner, 0, "idle");
    end
    wr(4'h4, 12'h001);
    tick(3);
    chk(tx_owner, 1, "idle_tx");
    wr(4'h4, 12'h000);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_howl();
    wr(4'h4, 12'h008);
    @(posedge pclk);
    converged <= 1'b1;
    tick(2);
    chk(hd_active, 0, "conv");
    @(posedge pclk);
    howl_evt <= 1'b1;
    @(posedge pclk);
    howl_evt <= 1'b0;
    tick(5);
    chk(hd_active, 1, "held");
    wr(4'h4, 12'h000);
    tick(2);
    chk(hd_active, 0, "freed");
    $display("t_howl done");
  endtask : t_howl
  task automatic t_line();
    @(posedge pclk);
    line_path_absent <= 1'b1;
    tick(3);
    chk(line_canceller_en, 1, "no_noise");
    @(posedge pclk);
    line_far_noise_setting <= 2'b01;
    tick(2);
    chk(line_canceller_en, 0, "drop");
    @(posedge pclk);
    line_path_absent <= 1'b0;
    line_path_found <= 1'b1;
    tick(1);
    chk({line_canceller_en, line_retrain, hd_active}, 3'b111, "reeng");
    wr(4'h2, 12'h2a1);
    @(posedge pclk);
    line_path_found <= 1'b0;
    line_path_absent <= 1'b1;
    tick(2);
    @(posedge pclk);
    line_path_absent <= 1'b0;
    line_path_found <= 1'b1;
    tick(3);
    chk(line_canceller_en, 0, "no_reeng");
    $display("t_line done");
  endtask : t_line
  task automatic results();
    if (u_mcu.hung) fail_count++;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    presetn = 1'b0;
    tx_power = 8'h00;
    tx_floor = 8'h00;
    rx_power = 8'h00;
    rx_floor = 8'h00;
    howl_evt = 1'b0;
    converged = 1'b0;
    line_path_absent = 1'b0;
    line_path_found = 1'b0;
    line_far_noise_setting = 2'b00;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_refuse();
    t_tx();
    t_rx();
    t_speech();
    t_hold();
    t_howl();
    t_line();
    results();
  end
endmodule : test_echo_control_config_regs
